// file: src/cvs_pkg.sv
// Shared constants and carrier types of the channel variable store.
// Assumes one clock at 10 MHz and a synchronous active-high reset.
package cvs_pkg;
	// ----------------------------------------------------------------
	// Addressing
	// ----------------------------------------------------------------
	localparam int CVS_VARS_PER_CH = 16;
	localparam int CVS_IDX_W = 4;
	localparam int CVS_CH_W = 4;
	localparam int CVS_ADDR_W = CVS_CH_W + CVS_IDX_W;
	localparam logic [CVS_ADDR_W-1:0] CVS_NO_POINTER = 8'h00;
	// ----------------------------------------------------------------
	// Memory types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CVS_PROM_RO,
		CVS_RAM_RO,
		CVS_PROTECTED_WRITE_TYPE,
		CVS_RAM_RW,
		CVS_BACKED_RAM_TYPE,
		CVS_PERIODIC_BACKUP_TYPE
	} cvs_mem_t;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam longint CVS_CLK_HZ = 64'd10000000;
	localparam longint CVS_SAVE_HOURS = 64'd10;
	localparam longint CVS_SAVE_CYCLES = CVS_SAVE_HOURS * 64'd3600 * CVS_CLK_HZ;
	// ----------------------------------------------------------------
	// Bus carrier
	// ----------------------------------------------------------------
	typedef struct packed {
		logic rd;
		logic wr;
		logic [CVS_ADDR_W-1:0] addr;
	} cvs_req_t;
endpackage

// file: src/cvs_store.sv
// Channel variable store: sixteen variables per channel, memory-type policy, indirection.
// Assumes a single access source; pointers never chain; EEPROM is modelled in flops.
`timescale 1ns/1ps
module cvs_store import cvs_pkg::*; #(
	parameter int DATA_W = 16,
	parameter int CHANNELS = 16,
	parameter longint SAVE_CYCLES = CVS_SAVE_CYCLES,
	parameter logic [CVS_ADDR_W-1:0] UNLOCK_ADDR = 8'h0D,
	parameter logic [3*CVS_VARS_PER_CH-1:0] MEM_TYPES = '0,
	parameter logic [CVS_VARS_PER_CH-1:0] CAN_INDIRECT = 16'h0000,
	parameter logic [DATA_W-1:0] PROM_VALUE = '0
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire cvs_req_t req_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic setup_wr_in,
	input wire logic [CVS_ADDR_W-1:0] setup_addr_in,
	input wire logic [CVS_ADDR_W-1:0] channel_setup_field_in,
	input wire logic [CVS_ADDR_W-1:0] ro_addr_in,
	input wire logic [DATA_W-1:0] ro_data_in,
	input wire logic ro_wr_in,
	output logic [DATA_W-1:0] rdata_out,
	output logic rvalid_out,
	output logic refused_out,
	output logic write_unlock_flag_out
);
	localparam int NV = CHANNELS * CVS_VARS_PER_CH;
	localparam int SC_W = 64;

	// The channel number is one hex digit, so more than sixteen channels cannot be addressed.
	if (CHANNELS < 1 || CHANNELS > 16 || DATA_W < 1 || SAVE_CYCLES < 1) begin : g_bad_params
		$error("cvs_store: unsupported parameter values");
	end

	typedef struct packed {
		logic [NV-1:0][DATA_W-1:0] ram;
		logic [NV-1:0][DATA_W-1:0] eeprom;
		logic [NV-1:0][CVS_ADDR_W-1:0] pointer;
		logic write_unlock_flag;
		logic [SC_W-1:0] save_count;
		logic [DATA_W-1:0] rdata;
		logic rvalid;
		logic refused;
	} cvs_state_t;

	cvs_state_t st;
	cvs_state_t next_st;

	// Memory type of a variable comes from its index; all channels share the layout.
	function automatic cvs_mem_t type_of(input logic [CVS_ADDR_W-1:0] a);
		logic [CVS_IDX_W-1:0] i;
		i = a[CVS_IDX_W-1:0];
		return cvs_mem_t'(MEM_TYPES[3*i +: 3]);
	endfunction

	function automatic logic is_backed(input cvs_mem_t t);
		return t == CVS_BACKED_RAM_TYPE || t == CVS_PERIODIC_BACKUP_TYPE;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic [CVS_ADDR_W-1:0] eff;
	cvs_mem_t eff_type;
	logic in_range;
	logic req_write_ok;
	logic [CVS_ADDR_W-1:0] ch_idx;

	always_comb begin
		next_st = st;
		next_st.rvalid = 1'b0;
		next_st.refused = 1'b0;
		// The address is channel in the upper digit and index in the lower.
		eff = req_in.addr;
		// A non-zero pointer redirects; one hop only, since chains are forbidden.
		if (st.pointer[req_in.addr] != CVS_NO_POINTER) begin
			eff = st.pointer[req_in.addr];
		end
		eff_type = type_of(eff);
		in_range = 32'(eff[CVS_ADDR_W-1:CVS_IDX_W]) < CHANNELS;
		ch_idx = eff;
		req_write_ok = 1'b0;
		if (req_in.rd) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = (eff_type == CVS_PROM_RO) ? PROM_VALUE : st.ram[ch_idx];
			if (eff_type == CVS_PROTECTED_WRITE_TYPE) begin
				next_st.rdata = st.eeprom[ch_idx];
			end
		end
		if (req_in.wr && in_range) begin
			unique case (eff_type)
				CVS_PROM_RO, CVS_RAM_RO: req_write_ok = 1'b0;
				CVS_PROTECTED_WRITE_TYPE: begin
					req_write_ok = st.write_unlock_flag;
					if (req_write_ok) begin
						next_st.eeprom[ch_idx] = wdata_in;
					end
				end
				CVS_RAM_RW: begin
					req_write_ok = 1'b1;
					next_st.ram[ch_idx] = wdata_in;
				end
				default: begin
					req_write_ok = 1'b1;
					next_st.ram[ch_idx] = wdata_in;
					if (st.write_unlock_flag) begin
						next_st.eeprom[ch_idx] = wdata_in;
					end
				end
			endcase
			next_st.refused = !req_write_ok;
			if (eff == UNLOCK_ADDR) begin
				next_st.write_unlock_flag = wdata_in[0];
			end
		end else if (req_in.wr) begin
			next_st.refused = 1'b1;
		end
		// Only indirect-capable variables accept a pointer.
		if (setup_wr_in && CAN_INDIRECT[setup_addr_in[CVS_IDX_W-1:0]]
				&& 32'(setup_addr_in[CVS_ADDR_W-1:CVS_IDX_W]) < CHANNELS) begin
			next_st.pointer[setup_addr_in] = channel_setup_field_in;
		end
		// Device-side updates of read-only RAM such as measured values.
		if (ro_wr_in && type_of(ro_addr_in) == CVS_RAM_RO
				&& 32'(ro_addr_in[CVS_ADDR_W-1:CVS_IDX_W]) < CHANNELS) begin
			next_st.ram[ro_addr_in] = ro_data_in;
		end
		// Periodic backup trades EEPROM wear for bounded loss of settings.
		if (st.save_count >= SC_W'(SAVE_CYCLES - 1)) begin
			next_st.save_count = '0;
			for (int v = 0; v < NV; v++) begin
				if (type_of(CVS_ADDR_W'(v)) == CVS_PERIODIC_BACKUP_TYPE) begin
					next_st.eeprom[v] = st.ram[v];
				end
			end
		end else begin
			next_st.save_count = st.save_count + SC_W'(1);
		end
		if (rst_in) begin
			// EEPROM and pointers survive reset; RAM is reloaded or cleared.
			next_st.write_unlock_flag = 1'b0;
			next_st.save_count = '0;
			next_st.rvalid = 1'b0;
			next_st.refused = 1'b0;
			next_st.rdata = '0;
			next_st.eeprom = st.eeprom;
			for (int v = 0; v < NV; v++) begin
				next_st.ram[v] = is_backed(type_of(CVS_ADDR_W'(v))) ? st.eeprom[v] : '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// EEPROM and pointers hold no reset value on purpose: they model nonvolatile cells.
	always_ff @(posedge clk_in) begin
		st <= next_st;
	end

	assign rdata_out = st.rdata;
	assign rvalid_out = st.rvalid;
	assign refused_out = st.refused;
	assign write_unlock_flag_out = st.write_unlock_flag;

	AST_UNLOCK_RESET: assert property (@(posedge clk_in) rst_in |=> !write_unlock_flag_out)
		else $error("unlock flag not cleared by reset");
	AST_PROM_REFUSED: assert property (@(posedge clk_in) disable iff (rst_in)
		req_in.wr && in_range && eff_type == CVS_PROM_RO |=> refused_out)
		else $error("PROM write not refused");
	AST_RO_KEEPS: assert property (@(posedge clk_in) disable iff (rst_in)
		req_in.wr && !ro_wr_in && in_range && eff_type == CVS_RAM_RO
		|=> st.ram[$past(eff)] == $past(st.ram[eff]))
		else $error("read-only RAM changed by bus write");
	AST_PROT_LOCKED: assert property (@(posedge clk_in) disable iff (rst_in)
		req_in.wr && in_range && eff_type == CVS_PROTECTED_WRITE_TYPE && !st.write_unlock_flag
		|=> refused_out)
		else $error("locked protected write accepted");
	AST_RW_TAKES: assert property (@(posedge clk_in) disable iff (rst_in)
		req_in.wr && in_range && eff_type == CVS_RAM_RW |=> st.ram[$past(eff)] == $past(wdata_in))
		else $error("plain RAM write lost");
	AST_BACKED_UNLOCKED: assert property (@(posedge clk_in) disable iff (rst_in)
		req_in.wr && in_range && is_backed(eff_type) && st.write_unlock_flag
		|=> st.eeprom[$past(eff)] == $past(wdata_in))
		else $error("unlocked backed write missed EEPROM");
	// The device-side address picks which backed variable is watched across a reset.
	AST_RESET_LOAD: assert property (@(posedge clk_in)
		rst_in && is_backed(type_of(ro_addr_in))
		&& 32'(ro_addr_in[CVS_ADDR_W-1:CVS_IDX_W]) < CHANNELS
		|=> st.ram[$past(ro_addr_in)] == $past(st.eeprom[ro_addr_in]))
		else $error("backed RAM not reloaded at reset");
	AST_READ_ANSWER: assert property (@(posedge clk_in) disable iff (rst_in)
		req_in.rd |=> rvalid_out)
		else $error("read not answered next cycle");
endmodule

// file: tb/cvs_master.sv
// Fieldbus master model: one read, write or pointer setup per call, answer sampled after.
// Assumes the store answers in the cycle after the request edge.
`timescale 1ns/1ps
module cvs_master import cvs_pkg::*; (
	input wire logic clk_in,
	output cvs_req_t req_out,
	output logic [15:0] wdata_out,
	output logic setup_wr_out,
	output logic [7:0] setup_addr_out,
	output logic [7:0] setup_field_out,
	input wire logic [15:0] rdata_in,
	input wire logic rvalid_in,
	input wire logic refused_in
);
	logic [15:0] got;
	logic rv;
	logic rf;
	initial begin
		req_out = '0;
		wdata_out = '0;
		setup_wr_out = 1'b0;
		setup_addr_out = '0;
		setup_field_out = '0;
	end
	// Released data shows the inverse, so a late sample cannot pass by luck.
	task automatic acc(input logic r, input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		req_out <= '{r, w, a};
		wdata_out <= d;
		@(posedge clk_in);
		req_out <= '0;
		wdata_out <= ~d;
		#1;
		got = rdata_in;
		rv = rvalid_in;
		rf = refused_in;
	endtask
	// Callers only ever point at plain variables, never at another pointer.
	task automatic point(input logic [7:0] v, input logic [7:0] p);
		@(posedge clk_in);
		setup_wr_out <= 1'b1;
		setup_addr_out <= v;
		setup_field_out <= p;
		@(posedge clk_in);
		setup_wr_out <= 1'b0;
		setup_field_out <= ~p;
	endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench of the channel variable store with a master model.
// Assumes index types: 0 PROM, 1 RAM_RO, 2 protected, 4 backed, 5 periodic, others RAM_RW.
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ro_wr = 1'b0;
	logic [7:0] ro_addr = '0;
	logic [15:0] ro_data = '0;
	cvs_pkg::cvs_req_t req;
	logic [15:0] wdata, rdata, v, w, x;
	logic [7:0] sa, sf, ra;
	logic swr, rv, rf, unl;
	int fails = 0;
	int n_compared = 0;
	localparam logic [15:0] PROM_V = 16'hA5C3;
	initial forever #50 clk = ~clk;
	cvs_store #(.CHANNELS(14), .SAVE_CYCLES(20),
		.MEM_TYPES(48'h6DB6DB6EC688), .CAN_INDIRECT(16'h0040), .PROM_VALUE(PROM_V)) i_dut (
		.clk_in(clk), .rst_in(rst), .req_in(req), .wdata_in(wdata), .setup_wr_in(swr),
		.setup_addr_in(sa), .channel_setup_field_in(sf), .ro_addr_in(ro_addr),
		.ro_data_in(ro_data), .ro_wr_in(ro_wr), .rdata_out(rdata), .rvalid_out(rv),
		.refused_out(rf), .write_unlock_flag_out(unl));
	cvs_master i_mst (.clk_in(clk), .req_out(req), .wdata_out(wdata), .setup_wr_out(swr),
		.setup_addr_out(sa), .setup_field_out(sf), .rdata_in(rdata), .rvalid_in(rv),
		.refused_in(rf));
	function automatic logic [7:0] sw(input logic [3:0] ch, input logic [3:0] ix);
		return {ch, ix};
	endfunction
	task automatic chk_d(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic e);
		i_mst.acc(1'b0, 1'b1, a, d);
		chk_b(i_mst.rf, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		i_mst.acc(1'b1, 1'b0, a, 16'h0000);
		chk_b(i_mst.rv, 1'b1);
		chk_d(i_mst.got, e);
	endtask
	task automatic reset_dut();
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
	endtask
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", fails, n_compared);
		if (fails == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		conclude();
	end
	initial begin
		v = $urandom(32'h6153672f);
		w = $urandom;
		reset_dut();
		chk_b(unl, 1'b0);
		wr(sw(4'h0, 4'h0), v, 1'b1);
		rd(sw(4'h0, 4'h0), PROM_V);
		wr(sw(4'h5, 4'h1), v, 1'b1);
		@(posedge clk);
		ro_wr <= 1'b1;
		ro_addr <= sw(4'h5, 4'h1);
		ro_data <= w;
		@(posedge clk);
		ro_wr <= 1'b0;
		rd(sw(4'h5, 4'h1), w);
		wr(sw(4'h0, 4'h2), v, 1'b1);
		wr(8'h0D, 16'h0001, 1'b0);
		chk_b(unl, 1'b1);
		wr(sw(4'h0, 4'h2), v, 1'b0);
		rd(sw(4'h0, 4'h2), v);
		wr(sw(4'h2, 4'h4), w, 1'b0);
		wr(8'h0D, 16'h0000, 1'b0);
		wr(sw(4'h2, 4'h4), ~w, 1'b0);
		rd(sw(4'h2, 4'h4), ~w);
		// Random words go through x so that v still names the protected cell's content.
		for (int i = 0; i < 8; i++) begin
			ra = sw(4'($urandom_range(13)), 4'(7 + $urandom_range(5)));
			x = $urandom;
			wr(ra, x, 1'b0);
			rd(ra, x);
		end
		wr(sw(4'hE, 4'h3), x, 1'b1);
		wr(sw(4'h1, 4'h5), v, 1'b0);
		repeat (30) @(posedge clk);
		i_mst.point(sw(4'h1, 4'h6), sw(4'h2, 4'h3));
		wr(sw(4'h1, 4'h6), w, 1'b0);
		rd(sw(4'h2, 4'h3), w);
		i_mst.point(sw(4'h1, 4'h6), 8'h00);
		wr(sw(4'h1, 4'h6), ~w, 1'b0);
		rd(sw(4'h2, 4'h3), w);
		rd(sw(4'h1, 4'h6), ~w);
		// The reload checker watches the backed variable named on the device-side address.
		ro_addr <= sw(4'h2, 4'h4);
		reset_dut();
		chk_b(unl, 1'b0);
		rd(sw(4'h2, 4'h4), w);
		rd(sw(4'h1, 4'h5), v);
		rd(sw(4'h0, 4'h2), v);
		wr(sw(4'h0, 4'h2), w, 1'b1);
		rd(ra, 16'h0000);
		conclude();
	end
endmodule
